/* rtl/sti_monitor.sv */
// Torque interlock monitor: gates the power stage from the two torque-off
// inputs, runs the self-test, watches stall, short and supply voltage.
// Assumes synchronous analog readings and an Avalon-MM master on clk_in.
`timescale 1ns/1ps
`include "sti_regs.svh"

module sti_monitor import sti_pkg::*; #(
  parameter int MS_CYC = `STI_MS_NS / `STI_CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic torque_off_input_a_in,
  input wire logic torque_off_input_b_in,
  input wire logic stage_fb_in,
  input wire logic short_detect_in,
  input wire logic [15:0] motor_current_in,
  input wire logic [15:0] bus_voltage_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic power_stage_en_out,
  output logic fault_alarm_out,
  output logic status_led_out,
  output logic [1:0] status_color_out,
  output logic [15:0] current_limit_out
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);
  localparam logic [5:0] FILT_LAST = 6'(`STI_FILT_CYC - 1);
  localparam logic [8:0] TEST_LAST = 9'(`STI_TEST_CYC - 1);
  localparam logic [10:0] LED_LAST = 11'(`STI_LED_PERIOD_MS - 1);
  localparam logic [10:0] LED_ON = 11'(`STI_LED_ON_MS);

  sti_state_t r_reg;
  sti_state_t r_next;

  logic req;
  logic wr_go;
  logic idle_cmd;
  logic both_hi;
  logic one_hi;
  logic both_rise;
  logic ms_tick;
  logic [31:0] wmask;
  logic [31:0] status_word;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
    merge16 = (old & ~m[15:0]) | (wd[15:0] & m[15:0]);
  endfunction

  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~r_reg.ack;
  assign wr_go = avs_write_in & r_reg.ack;
  assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign idle_cmd = wr_go && avs_address_in == `STI_OFF_CTRL
                    && avs_byteenable_in[0]
                    && avs_writedata_in[`STI_CTRL_IDLE_BIT];

  assign both_hi = r_reg.filt == 2'b11;
  assign one_hi = r_reg.filt[0] ^ r_reg.filt[1];
  // Filter about to settle on both high; read from registers only
  assign both_rise = !both_hi && r_reg.s2 == 2'b11
                     && r_reg.fcnt == FILT_LAST;
  assign ms_tick = r_reg.pre == MS_LAST;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STI_ST_STAGE_BIT] = r_reg.stage;
    status_word[`STI_ST_STO_FLT_BIT] = one_hi;
    status_word[`STI_ST_PASS_BIT] = r_reg.st == ST_PASS;
    status_word[`STI_ST_BUSY_BIT] = r_reg.st == ST_TEST;
    status_word[`STI_ST_STALL_BIT] = r_reg.stall_l;
    status_word[`STI_ST_SHORT_BIT] = r_reg.short_l;
    status_word[`STI_ST_OV_BIT] = r_reg.ov;
    status_word[`STI_ST_UV_BIT] = r_reg.uv;
    status_word[`STI_ST_IN_LSB +: 2] = r_reg.filt;
    status_word[`STI_ST_TFAIL_BIT] = r_reg.st == ST_FAIL;
  end

  always_comb begin
    r_next = r_reg;
    // Input synchroniser and deglitch filter
    r_next.s1 = {torque_off_input_b_in, torque_off_input_a_in};
    r_next.s2 = r_reg.s1;
    if (r_reg.s2 == r_reg.filt) begin
      r_next.fcnt = 6'h00;
    end else if (r_reg.fcnt == FILT_LAST) begin
      r_next.fcnt = 6'h00;
      r_next.filt = r_reg.s2;
    end else begin
      r_next.fcnt = r_reg.fcnt + 6'h01;
    end

    // Self-test: stage held off, feedback must stay low for the whole run
    case (r_reg.st)
      ST_TEST: begin
        r_next.tcnt = r_reg.tcnt + 9'h001;
        if (stage_fb_in) begin
          r_next.st = ST_FAIL;
        end else if (r_reg.tcnt == TEST_LAST) begin
          r_next.st = ST_PASS;
        end
      end
      ST_PASS: begin
        if (!both_hi) begin
          r_next.st = ST_WAIT;
        end
      end
      ST_FAIL, ST_WAIT: begin
        r_next.st = r_reg.st;
      end
      default: begin
        r_next.st = ST_FAIL;
      end
    endcase
    if (both_rise) begin
      r_next.st = ST_TEST;
      r_next.tcnt = 9'h000;
    end

    // Protection monitors
    r_next.pre = ms_tick ? 16'h0000 : r_reg.pre + 16'h0001;
    if (motor_current_in <= r_reg.sthr) begin
      r_next.stall_ms = 16'h0000;
    end else if (ms_tick && r_reg.stall_ms != r_reg.stmo) begin
      r_next.stall_ms = r_reg.stall_ms + 16'h0001;
    end
    r_next.stall_l = (r_reg.stall_ms == r_reg.stmo
                      && motor_current_in > r_reg.sthr)
                     || (r_reg.stall_l && !idle_cmd);
    r_next.short_l = short_detect_in
                     || (r_reg.short_l && !idle_cmd);
    r_next.ov = bus_voltage_in > r_reg.ovt;
    r_next.uv = bus_voltage_in < r_reg.uvt;

    r_next.stage = both_hi && r_reg.st == ST_PASS && !r_reg.short_l
                   && !r_reg.stall_l && !r_reg.ov && !r_reg.uv;
    r_next.fault = one_hi || r_reg.st == ST_FAIL || r_reg.short_l
                   || r_reg.stall_l || r_reg.ov || r_reg.uv;

    // Status pulse every two seconds
    if (ms_tick) begin
      r_next.led_ms = r_reg.led_ms == LED_LAST ? 11'h000
                      : r_reg.led_ms + 11'h001;
    end
    r_next.led = r_reg.led_ms < LED_ON;

    // Avalon slave: one wait state, read data latched in that state
    r_next.ack = req & ~r_reg.ack;
    if (req && !r_reg.ack) begin
      case (avs_address_in)
        `STI_OFF_STATUS: r_next.rdata = status_word;
        `STI_OFF_CUR_LIM: r_next.rdata = {16'h0000, r_reg.lim};
        `STI_OFF_STALL_THR: r_next.rdata = {16'h0000, r_reg.sthr};
        `STI_OFF_STALL_TMO: r_next.rdata = {16'h0000, r_reg.stmo};
        `STI_OFF_OV_THR: r_next.rdata = {16'h0000, r_reg.ovt};
        `STI_OFF_UV_THR: r_next.rdata = {16'h0000, r_reg.uvt};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      case (avs_address_in)
        `STI_OFF_CUR_LIM: begin
          r_next.lim = merge16(r_reg.lim, avs_writedata_in, wmask);
          if (r_next.lim > `STI_CUR_MAX) begin
            r_next.lim = `STI_CUR_MAX;
          end
        end
        `STI_OFF_STALL_THR: begin
          r_next.sthr = merge16(r_reg.sthr, avs_writedata_in, wmask);
          if (r_next.sthr > `STI_CUR_MAX) begin
            r_next.sthr = `STI_CUR_MAX;
          end
        end
        `STI_OFF_STALL_TMO: begin
          r_next.stmo = merge16(r_reg.stmo, avs_writedata_in, wmask);
          if (r_next.stmo == 16'h0000) begin
            r_next.stmo = 16'h0001;
          end else if (r_next.stmo > `STI_STALL_TMO_MAX) begin
            r_next.stmo = `STI_STALL_TMO_MAX;
          end
        end
        `STI_OFF_OV_THR: begin
          r_next.ovt = merge16(r_reg.ovt, avs_writedata_in, wmask);
        end
        `STI_OFF_UV_THR: begin
          r_next.uvt = merge16(r_reg.uvt, avs_writedata_in, wmask);
        end
        default: begin
          r_next.ovt = r_reg.ovt;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_reg <= '0;
      r_reg.st <= ST_TEST;
      r_reg.lim <= `STI_CUR_LIM_RST;
      r_reg.sthr <= `STI_STALL_THR_RST;
      r_reg.stmo <= `STI_STALL_TMO_RST;
      r_reg.ovt <= `STI_OV_RST;
      r_reg.uvt <= `STI_UV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata_out = r_reg.rdata;
  assign power_stage_en_out = r_reg.stage;
  assign fault_alarm_out = r_reg.fault;
  assign status_led_out = r_reg.led;
  assign status_color_out = {r_reg.fault, r_reg.stage};
  assign current_limit_out = r_reg.lim;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_arm;
    r_reg.filt != 2'b11 ##1 r_reg.filt == 2'b11;
  endsequence

  sequence s_test_run;
    r_reg.st == ST_TEST && !r_reg.stage;
  endsequence

  a_stage_needs_both: assert property (
    power_stage_en_out |-> $past(r_reg.filt) == 2'b11)
    else $error("stage enabled without both inputs high");

  a_released_quiet: assert property (
    (r_reg.filt == 2'b00 && r_reg.st == ST_WAIT && !r_reg.short_l
     && !r_reg.stall_l && !r_reg.ov && !r_reg.uv) [*2]
    |-> !fault_alarm_out && !power_stage_en_out)
    else $error("released state shows fault or stage");

  a_one_high_fault: assert property (
    (r_reg.filt == 2'b01 || r_reg.filt == 2'b10)
    |=> fault_alarm_out && !power_stage_en_out)
    else $error("single input high not flagged");

  a_rearm_test: assert property (
    s_arm |-> s_test_run)
    else $error("self-test not started on re-arm");

  a_stage_after_pass: assert property (
    $rose(power_stage_en_out) |-> $past(r_reg.st) == ST_PASS
    && $past(r_reg.st, 2) != ST_FAIL)
    else $error("stage enabled without passed self-test");

  a_stall_cause: assert property (
    $rose(r_reg.stall_l) |-> $past(motor_current_in > r_reg.sthr)
    && $past(r_reg.stall_ms) == $past(r_reg.stmo))
    else $error("stall declared before timeout");

  a_limit_range: assert property (
    r_reg.lim <= `STI_CUR_MAX && r_reg.sthr <= `STI_CUR_MAX)
    else $error("current setting above maximum");

  a_short_hold: assert property (
    r_reg.short_l && !idle_cmd |=> r_reg.short_l ##1 !power_stage_en_out)
    else $error("short latch released without idle command");

  a_voltage_cut: assert property (
    (bus_voltage_in > r_reg.ovt || bus_voltage_in < r_reg.uvt)
    |=> ##1 !power_stage_en_out)
    else $error("stage on outside voltage window");

  a_led_period: assert property (
    $rose(status_led_out) |-> $past(r_reg.led_ms) == 11'h000)
    else $error("status pulse out of phase");

  a_filter_source: assert property (
    $changed(r_reg.filt) |-> $past(r_reg.fcnt) == FILT_LAST
    && $past(r_reg.s2) == r_reg.filt)
    else $error("filter output changed too early");

endmodule

/* rtl/sti_pkg.sv */
// Types of the torque interlock monitor.
// Assumes sti_regs.svh for the numbers.
package sti_pkg;

  typedef enum logic [1:0] {
    ST_TEST,
    ST_PASS,
    ST_FAIL,
    ST_WAIT
  } sti_test_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] filt;
    logic [5:0] fcnt;
    sti_test_t st;
    logic [8:0] tcnt;
    logic short_l;
    logic stall_l;
    logic ov;
    logic uv;
    logic [15:0] lim;
    logic [15:0] sthr;
    logic [15:0] stmo;
    logic [15:0] ovt;
    logic [15:0] uvt;
    logic [15:0] pre;
    logic [15:0] stall_ms;
    logic [10:0] led_ms;
    logic led;
    logic stage;
    logic fault;
    logic ack;
    logic [31:0] rdata;
  } sti_state_t;

endpackage

/* rtl/sti_regs.svh */
// Constants of the torque interlock monitor: offsets, fields, resets, times.
// Assumes a 40 MHz clock and 32-bit Avalon-MM byte addressing.
// Operation
// - The power stage is enabled only while both torque-off inputs are high.
// - Both inputs low keeps the stage disabled and raises no fault; a failed self-test keeps fault raised until both inputs go high again.
// - Exactly one input high keeps the stage disabled and raises a fault.
// - A self-test runs at power-on and whenever both inputs go high together.
// - Only a passed self-test with both inputs high lets the motor run.
// - A stall is declared when current stays above threshold for the timeout.
// - Current limit and stall threshold are set in 0.1 A steps up to 180 A.
// - A short circuit stops the motor until an idle command is given.
// - Over and under voltage limits are set in 0.1 V, default 60 V and 5 V.
// - The status indicator pulses once every two seconds after power-on.
`ifndef STI_REGS_SVH
`define STI_REGS_SVH

`define STI_OFF_CTRL 5'h00
`define STI_OFF_STATUS 5'h04
`define STI_OFF_CUR_LIM 5'h08
`define STI_OFF_STALL_THR 5'h0C
`define STI_OFF_STALL_TMO 5'h10
`define STI_OFF_OV_THR 5'h14
`define STI_OFF_UV_THR 5'h18

`define STI_CTRL_IDLE_BIT 0

`define STI_ST_STAGE_BIT 0
`define STI_ST_STO_FLT_BIT 1
`define STI_ST_PASS_BIT 2
`define STI_ST_BUSY_BIT 3
`define STI_ST_STALL_BIT 4
`define STI_ST_SHORT_BIT 5
`define STI_ST_OV_BIT 6
`define STI_ST_UV_BIT 7
`define STI_ST_IN_LSB 8
`define STI_ST_TFAIL_BIT 10

`define STI_CUR_MAX 16'h0708
`define STI_CUR_LIM_RST 16'h04B0
`define STI_STALL_THR_RST 16'h0708
`define STI_STALL_TMO_RST 16'h01F4
`define STI_STALL_TMO_MAX 16'hFDE8
`define STI_OV_RST 16'h0258
`define STI_UV_RST 16'h0032

`define STI_CLK_PERIOD_NS 25
`define STI_MS_NS 1000000
`define STI_FILT_NS 1000
`define STI_FILT_CYC (`STI_FILT_NS / `STI_CLK_PERIOD_NS)
`define STI_TEST_NS 10000
`define STI_TEST_CYC (`STI_TEST_NS / `STI_CLK_PERIOD_NS)
`define STI_LED_PERIOD_MS 2000
`define STI_LED_ON_MS 100

`endif

/* test/sti_safety_src.sv */
// Model of the external safety circuit driving the torque-off pair.
// Assumes clk_in is the monitor's clock; split_in forces an unequal pair while arm_in is high.
`timescale 1ns/1ps
module sti_safety_src (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic arm_in,
  input wire logic split_in,
  output logic torque_off_input_a_out,
  output logic torque_off_input_b_out
);
  // Both lines move together unless a split is commanded
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      torque_off_input_a_out <= 1'b0;
      torque_off_input_b_out <= 1'b0;
    end else begin
      torque_off_input_a_out <= arm_in;
      torque_off_input_b_out <= arm_in & ~split_in;
    end
  end
endmodule

/* test/test_safe_torque_interlock_monitor.sv */
// Self-checking bench for the torque interlock monitor.
// Assumes a 40 MHz clock and a 20-cycle millisecond to shorten counts.
`timescale 1ns/1ps
`include "sti_regs.svh"
module test_safe_torque_interlock_monitor;
  localparam int MS = 20;
  logic clk_in, rst_in, arm, split, fb, shrt, rd, wr;
  logic [15:0] cur, volt, clim;
  logic [4:0] addr;
  logic [31:0] wdat, rdat;
  logic wreq, stage, fault, led, ta, tb;
  logic [1:0] color;
  int n_errors, checks_done;

  sti_safety_src u_sti_safety_src (.clk_in(clk_in), .rst_in(rst_in),
    .arm_in(arm), .split_in(split), .torque_off_input_a_out(ta),
    .torque_off_input_b_out(tb));
  sti_monitor #(.MS_CYC(MS)) u_sti_monitor (.clk_in(clk_in),
    .rst_in(rst_in), .torque_off_input_a_in(ta),
    .torque_off_input_b_in(tb), .stage_fb_in(fb),
    .short_detect_in(shrt), .motor_current_in(cur),
    .bus_voltage_in(volt), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .power_stage_en_out(stage),
    .fault_alarm_out(fault), .status_led_out(led),
    .status_color_out(color), .current_limit_out(clim));

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdat <= d;
    // Sampled at the edge, before that edge updates the slave
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic st_chk(input int b, input logic exp);
    logic [31:0] q;
    bus(1'b0, `STI_OFF_STATUS, 32'h0000_0000, q);
    chk({31'h0000_0000, q[b]}, {31'h0000_0000, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Waits on fault when sel is set, on stage otherwise
  task automatic wait_for(input bit sel, input logic exp, input int lim);
    int n;
    logic s;
    n = 0;
    s = sel ? fault : stage;
    while (s !== exp && n < lim) begin
      @(negedge clk_in);
      n++;
      s = sel ? fault : stage;
    end
    chk({31'h0000_0000, s}, {31'h0000_0000, exp});
  endtask

  task automatic t_reset_regs();
    chk({30'h0000_0000, stage, fault}, 32'h0000_0000);
    rd_chk(`STI_OFF_CUR_LIM, `STI_CUR_LIM_RST);
    rd_chk(`STI_OFF_STALL_THR, `STI_STALL_THR_RST);
    rd_chk(`STI_OFF_STALL_TMO, `STI_STALL_TMO_RST);
    rd_chk(`STI_OFF_OV_THR, `STI_OV_RST);
    rd_chk(`STI_OFF_UV_THR, `STI_UV_RST);
    wr_reg(5'h1C, 32'hFFFF_FFFF);
    rd_chk(5'h1C, 32'h0000_0000);
    rd_chk(`STI_OFF_CTRL, 32'h0000_0000);
  endtask

  task automatic t_arm_run();
    int hits;
    hits = 0;
    @(posedge clk_in);
    arm <= 1'b1;
    wait_cyc(200);
    chk({31'h0000_0000, stage}, 32'h0000_0000);
    st_chk(`STI_ST_BUSY_BIT, 1'b1);
    wait_for(1'b0, 1'b1, 700);
    chk({30'h0000_0000, color}, 32'h0000_0001);
    st_chk(`STI_ST_PASS_BIT, 1'b1);
    @(posedge clk_in);
    split <= 1'b1;
    repeat (10) @(posedge clk_in);
    split <= 1'b0;
    repeat (80) begin
      @(negedge clk_in);
      if (fault !== 1'b0 || stage !== 1'b1) hits++;
    end
    chk(hits, 0);
  endtask

  task automatic t_one_sided();
    @(posedge clk_in);
    split <= 1'b1;
    wait_for(1'b1, 1'b1, 100);
    chk({30'h0000_0000, color}, 32'h0000_0002);
    chk({31'h0000_0000, stage}, 32'h0000_0000);
    st_chk(`STI_ST_STO_FLT_BIT, 1'b1);
    @(posedge clk_in);
    arm <= 1'b0;
    split <= 1'b0;
    wait_cyc(100);
    chk({30'h0000_0000, stage, fault}, 32'h0000_0000);
    chk({30'h0000_0000, color}, 32'h0000_0000);
  endtask

  task automatic t_selftest_fail();
    @(posedge clk_in);
    fb <= 1'b1;
    arm <= 1'b1;
    wait_cyc(600);
    chk({31'h0000_0000, stage}, 32'h0000_0000);
    st_chk(`STI_ST_TFAIL_BIT, 1'b1);
    @(posedge clk_in);
    fb <= 1'b0;
    arm <= 1'b0;
    wait_cyc(60);
    @(posedge clk_in);
    arm <= 1'b1;
    wait_for(1'b0, 1'b1, 700);
  endtask

  task automatic t_short();
    @(posedge clk_in);
    shrt <= 1'b1;
    repeat (5) @(posedge clk_in);
    shrt <= 1'b0;
    wait_cyc(60);
    chk({31'h0000_0000, stage}, 32'h0000_0000);
    st_chk(`STI_ST_SHORT_BIT, 1'b1);
    wr_reg(`STI_OFF_CTRL, 32'h0000_0001);
    st_chk(`STI_ST_SHORT_BIT, 1'b0);
  endtask

  task automatic t_stall_limits();
    wr_reg(`STI_OFF_CUR_LIM, 32'h0000_FFFF);
    rd_chk(`STI_OFF_CUR_LIM, `STI_CUR_MAX);
    wr_reg(`STI_OFF_CUR_LIM, 32'h0000_03E8);
    wait_cyc(1);
    chk(clim, 32'h0000_03E8);
    wr_reg(`STI_OFF_STALL_TMO, 32'h0000_0000);
    rd_chk(`STI_OFF_STALL_TMO, 32'h0000_0001);
    wr_reg(`STI_OFF_STALL_TMO, 32'h0000_0003);
    wr_reg(`STI_OFF_STALL_THR, 32'h0000_0064);
    @(posedge clk_in);
    cur <= 16'h00C8;
    wait_cyc(20);
    st_chk(`STI_ST_STALL_BIT, 1'b0);
    wait_cyc(100);
    st_chk(`STI_ST_STALL_BIT, 1'b1);
    chk({31'h0000_0000, stage}, 32'h0000_0000);
    @(posedge clk_in);
    cur <= 16'h0000;
    wr_reg(`STI_OFF_CTRL, 32'h0000_0001);
    st_chk(`STI_ST_STALL_BIT, 1'b0);
  endtask

  task automatic t_volt();
    int i;
    logic [15:0] v[3] = '{16'h02BC, 16'h001E, 16'h00F0};
    for (i = 0; i < 3; i++) begin
      @(posedge clk_in);
      volt <= v[i];
      wait_cyc(5);
      st_chk(`STI_ST_OV_BIT, i == 0);
      st_chk(`STI_ST_UV_BIT, i == 1);
    end
    wr_reg(`STI_OFF_OV_THR, 32'h0000_02EE);
    @(posedge clk_in);
    volt <= 16'h02BC;
    wait_cyc(5);
    st_chk(`STI_ST_OV_BIT, 1'b0);
  endtask

  task automatic t_led();
    int on;
    on = 0;
    repeat (`STI_LED_PERIOD_MS * MS) begin
      @(negedge clk_in);
      if (led === 1'b1) on++;
    end
    chk(on, `STI_LED_ON_MS * MS);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    #1500000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    rst_in = 1'b1;
    {arm, split, fb, shrt, rd, wr} = 6'h00;
    cur = 16'h0000;
    volt = 16'h00F0;
    addr = 5'h00;
    wdat = 32'h0000_0000;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    wait_cyc(1);
    t_reset_regs();
    t_arm_run();
    t_one_sided();
    t_selftest_fail();
    t_short();
    t_stall_limits();
    t_volt();
    t_led();
    tally_and_finish();
  end
endmodule
